// ---- src/mute_select_map.vh ----
// Register offsets, field positions, reset values and source codes of the mute source selector
`ifndef MUTE_SELECT_MAP_VH
`define MUTE_SELECT_MAP_VH

`define PORT0_MUTE_SELECT_OFFSET 32'h40000018
`define PORT1_MUTE_SELECT_OFFSET 32'h4000001c
`define PORT2_MUTE_SELECT_OFFSET 32'h40000020
`define CLOCK_MODE_OFFSET 32'h40000024
`define CLOCK_STATUS_OFFSET 32'h40000028

`define MUTE_SRC_MSB 2
`define MUTE_SRC_LSB 0
`define MUTE_SRC_RESET 3'h0

`define SRC_CONST_ZERO 3'h0
`define SRC_PORT2_RX_HF_CLK 3'h4

`define TX_CLK_MODE_BIT 0
`define TX_PIN_DIR_BIT 1
`define RX_CLK_MODE_BIT 2
`define RX_PIN_DIR_BIT 3
`define CLOCK_MODE_RESET 4'h0

`define BIT_CLK_EXT_IN 2'h0
`define BIT_CLK_INTERNAL 2'h1
`define BIT_CLK_EXT_OUT 2'h2
`define BIT_CLK_INVALID 2'h3

`define RESERVED_READ_FILL 29'h0

`endif

// ---- src/mute_source_mux.v ----
// One eight-way mute source multiplexer with a registered output
`timescale 1ns/1ps
`default_nettype none
`include "mute_select_map.vh"

module mute_source_mux
(
	input wire sys_clk_in,
	input wire nrst_in,
	input wire [2:0] select_in,
	input wire [7:0] sources_in,
	output reg mute_out
);

	// Output follows a new code on the next edge, no handshake needed
	always @(posedge sys_clk_in)
	begin
		if (!nrst_in)
			mute_out <= 1'b0;
		else if (select_in == `SRC_CONST_ZERO)
			mute_out <= 1'b0;
		else
			mute_out <= sources_in[select_in];
	end

endmodule
`default_nettype wire

// ---- src/audio_port_mute_input_select.v ----
// Mute input source selection for three audio serial ports, with bit clock mode decode
// Functional notes
// - Port 1 mute source from 3-bit code: zero, three shared pins, HF clock, three SPI pins
// - Port 2 mute source uses the same eight-way code in its own register
// - Selector bits 31 to 3 are undefined on read; software writes zeros
// - On the smallest variant the port 2 selector register is reserved
// - Every selector resets to zero, so all mute inputs see constant zero
// - Tx bit clock internal when mode 1 and direction 1; external input when 0 and 0
// - Tx bit clock external with output pin when mode 0 and direction 1
// - Rx bit clock follows the same three mode definitions
// - Port 0 mute source uses the same selector in its own register, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "mute_select_map.vh"

module audio_port_mute_input_select
#(
	parameter SMALL_VARIANT = 0
)
(
	input wire sys_clk_in,
	input wire nrst_in,
	input wire [31:0] addr_in,
	input wire [31:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [31:0] rdata_out,
	input wire serial_data_pin_shared_in,
	input wire shared_pin_b_in,
	input wire shared_pin_c_in,
	input wire port2_rx_high_freq_clock_in,
	input wire spi0_pin_a_in,
	input wire spi0_pin_b_in,
	input wire spi0_pin_c_in,
	output wire port0_mute_out,
	output wire port1_mute_out,
	output wire port2_mute_out,
	output reg [1:0] tx_bit_clock_mode_out,
	output reg [1:0] rx_bit_clock_mode_out
);

	////////////////////////////////////////////////////////////////////////////
	// Decode of one clock-mode bit and one pin-direction bit
	function [1:0] clock_mode;
		input mode_bit;
		input dir_bit;
		begin
			case ({mode_bit, dir_bit})
				2'b11: clock_mode = `BIT_CLK_INTERNAL;
				2'b00: clock_mode = `BIT_CLK_EXT_IN;
				2'b01: clock_mode = `BIT_CLK_EXT_OUT;
				default: clock_mode = `BIT_CLK_INVALID;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Selector field of a write word; reserved bits are dropped, never stored
	function [2:0] selector_field;
		input [31:0] word;
		begin
			selector_field = word[`MUTE_SRC_MSB:`MUTE_SRC_LSB];
		end
	endfunction

	// Read word of one selector; reserved bits read as zero, a legal undefined value
	function [31:0] selector_word;
		input [2:0] field;
		begin
			selector_word = {`RESERVED_READ_FILL, field};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a change counts once stages two and three agree
	reg [6:0] pin_s1_reg;
	reg [6:0] pin_s2_reg;
	reg [6:0] pin_s3_reg;
	reg [6:0] pin_clean_reg;
	wire [6:0] pins_raw;

	assign pins_raw = {spi0_pin_c_in, spi0_pin_b_in, spi0_pin_a_in,
		port2_rx_high_freq_clock_in, shared_pin_c_in, shared_pin_b_in,
		serial_data_pin_shared_in};

	always @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			pin_s1_reg <= 7'h00;
			pin_s2_reg <= 7'h00;
			pin_s3_reg <= 7'h00;
			pin_clean_reg <= 7'h00;
		end
		else
		begin
			pin_s1_reg <= pins_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_clean_reg <= (pin_s2_reg & pin_s3_reg) | (pin_clean_reg & (pin_s2_reg ^ pin_s3_reg));
		end
	end

	// Bit 0 is never selected; code zero is forced low in the mux
	wire [7:0] sources;
	assign sources = {pin_clean_reg, 1'b0};

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	reg [2:0] port0_mute_select_reg;
	reg [2:0] port1_mute_select_reg;
	reg [2:0] port2_mute_select_reg;
	reg [3:0] clock_mode_reg;
	wire port2_present;

	// Smallest variant keeps the port 2 selector out
	assign port2_present = (SMALL_VARIANT == 0);

	always @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			port0_mute_select_reg <= `MUTE_SRC_RESET;
			port1_mute_select_reg <= `MUTE_SRC_RESET;
			port2_mute_select_reg <= `MUTE_SRC_RESET;
			clock_mode_reg <= `CLOCK_MODE_RESET;
		end
		else if (wr_in)
		begin
			case (addr_in)
				`PORT0_MUTE_SELECT_OFFSET:
					port0_mute_select_reg <= selector_field(wdata_in);
				`PORT1_MUTE_SELECT_OFFSET:
					port1_mute_select_reg <= selector_field(wdata_in);
				`PORT2_MUTE_SELECT_OFFSET:
					if (port2_present)
						port2_mute_select_reg <= selector_field(wdata_in);
				`CLOCK_MODE_OFFSET:
					clock_mode_reg <= wdata_in[3:0];
				default:
					clock_mode_reg <= clock_mode_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port; upper bits of selectors read as zero, one legal value of undefined
	always @(posedge sys_clk_in)
	begin
		if (!nrst_in)
			rdata_out <= 32'h00000000;
		else if (rd_in)
		begin
			case (addr_in)
				`PORT0_MUTE_SELECT_OFFSET:
					rdata_out <= selector_word(port0_mute_select_reg);
				`PORT1_MUTE_SELECT_OFFSET:
					rdata_out <= selector_word(port1_mute_select_reg);
				`PORT2_MUTE_SELECT_OFFSET:
					// Reserved selector on the smallest variant reads as zero
					rdata_out <= port2_present ? selector_word(port2_mute_select_reg)
						: 32'h00000000;
				`CLOCK_MODE_OFFSET:
					rdata_out <= {28'h0000000, clock_mode_reg};
				`CLOCK_STATUS_OFFSET:
					rdata_out <= {28'h0000000, rx_bit_clock_mode_out, tx_bit_clock_mode_out};
				default:
					rdata_out <= 32'h00000000;
			endcase
		end
		else
			rdata_out <= 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bit clock mode decode, registered
	always @(posedge sys_clk_in)
	begin
		if (!nrst_in)
		begin
			tx_bit_clock_mode_out <= `BIT_CLK_EXT_IN;
			rx_bit_clock_mode_out <= `BIT_CLK_EXT_IN;
		end
		else
		begin
			tx_bit_clock_mode_out <= clock_mode(clock_mode_reg[`TX_CLK_MODE_BIT],
				clock_mode_reg[`TX_PIN_DIR_BIT]);
			rx_bit_clock_mode_out <= clock_mode(clock_mode_reg[`RX_CLK_MODE_BIT],
				clock_mode_reg[`RX_PIN_DIR_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Three mutes; selectors switch on the next edge
	mute_source_mux port0_mux
	(
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.select_in(port0_mute_select_reg),
		.sources_in(sources),
		.mute_out(port0_mute_out)
	);

	mute_source_mux port1_mux
	(
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.select_in(port1_mute_select_reg),
		.sources_in(sources),
		.mute_out(port1_mute_out)
	);

	mute_source_mux port2_mux
	(
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.select_in(port2_mute_select_reg),
		.sources_in(sources),
		.mute_out(port2_mute_out)
	);

endmodule
`default_nettype wire

// ---- testbench/mute_select_chk.sv ----
// Port checks for the mute source selector
`timescale 1ns/1ps
`default_nettype none
`include "mute_select_map.vh"
module mute_select_chk
(
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic [31:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic port0_mute_out,
	input wire logic port1_mute_out,
	input wire logic port2_mute_out,
	input wire logic [1:0] tx_bit_clock_mode_out,
	input wire logic [1:0] rx_bit_clock_mode_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);
	// Expected mode codes of a clock-mode write: 0 ext input, 1 internal, 2 ext output
	wire logic [1:0] tx_exp;
	wire logic [1:0] rx_exp;
	assign tx_exp = {wdata_in[1] ^ wdata_in[0], wdata_in[0]};
	assign rx_exp = {wdata_in[3] ^ wdata_in[2], wdata_in[2]};
	////////////////////////
	property p_rst;
		$rose(nrst_in) |-> rdata_out == 32'h0 && !port0_mute_out && !port1_mute_out
			&& !port2_mute_out && tx_bit_clock_mode_out == 2'h0 && rx_bit_clock_mode_out == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("state after reset");
	property p_tx;
		wr_in && addr_in == `CLOCK_MODE_OFFSET |->
			##2 tx_bit_clock_mode_out == $past(tx_exp, 2);
	endproperty
	a_tx: assert property (p_tx) else $error("tx clock mode");
	property p_rx;
		wr_in && addr_in == `CLOCK_MODE_OFFSET |->
			##2 rx_bit_clock_mode_out == $past(rx_exp, 2);
	endproperty
	a_rx: assert property (p_rx) else $error("rx clock mode");
	property p_zero0;
		wr_in && addr_in == `PORT0_MUTE_SELECT_OFFSET && wdata_in[2:0] == 3'h0 |-> ##2 !port0_mute_out;
	endproperty
	a_zero0: assert property (p_zero0) else $error("port 0 code zero");
	property p_zero1;
		wr_in && addr_in == `PORT1_MUTE_SELECT_OFFSET && wdata_in[2:0] == 3'h0 |-> ##2 !port1_mute_out;
	endproperty
	a_zero1: assert property (p_zero1) else $error("port 1 code zero");
	property p_zero2;
		wr_in && addr_in == `PORT2_MUTE_SELECT_OFFSET && wdata_in[2:0] == 3'h0 |-> ##2 !port2_mute_out;
	endproperty
	a_zero2: assert property (p_zero2) else $error("port 2 code zero");
	property p_idle;
		!rd_in |=> rdata_out == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside read");
	property p_resv;
		rd_in |=> rdata_out[31:4] == 28'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved read bits");
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the mute source selector
`timescale 1ns/1ps
`default_nettype none
`include "mute_select_map.vh"
module tb;
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [31:0] addr_in = 32'h0;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] src = 8'h0;
	logic [31:0] seed = 32'h99cf;
	logic [31:0] offs [3] = '{`PORT0_MUTE_SELECT_OFFSET, `PORT1_MUTE_SELECT_OFFSET,
		`PORT2_MUTE_SELECT_OFFSET};
	wire [31:0] rdata;
	wire [2:0] mute;
	wire [31:0] rdata_small;
	wire [2:0] mute_small;
	wire [1:0] txm;
	wire [1:0] rxm;
	integer failures = 0;
	integer checks = 0;
	integer cyc = 0;
	integer sel [3] = '{0, 0, 0};
	integer p, c;
	logic [31:0] e;
	audio_port_mute_input_select dut
	(
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata),
		.serial_data_pin_shared_in(src[1]),
		.shared_pin_b_in(src[2]),
		.shared_pin_c_in(src[3]),
		.port2_rx_high_freq_clock_in(src[4]),
		.spi0_pin_a_in(src[5]),
		.spi0_pin_b_in(src[6]),
		.spi0_pin_c_in(src[7]),
		.port0_mute_out(mute[0]),
		.port1_mute_out(mute[1]),
		.port2_mute_out(mute[2]),
		.tx_bit_clock_mode_out(txm),
		.rx_bit_clock_mode_out(rxm)
	);
	// Smallest variant: the port 2 selector is reserved
	audio_port_mute_input_select #(.SMALL_VARIANT(1)) dut_small
	(
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata_small),
		.serial_data_pin_shared_in(src[1]),
		.shared_pin_b_in(src[2]),
		.shared_pin_c_in(src[3]),
		.port2_rx_high_freq_clock_in(src[4]),
		.spi0_pin_a_in(src[5]),
		.spi0_pin_b_in(src[6]),
		.spi0_pin_c_in(src[7]),
		.port0_mute_out(mute_small[0]),
		.port1_mute_out(mute_small[1]),
		.port2_mute_out(mute_small[2]),
		.tx_bit_clock_mode_out(),
		.rx_bit_clock_mode_out()
	);
	always #2.5 sys_clk_in = ~sys_clk_in;
	////////////////////////
	function [31:0] lfsr(input [31:0] s);
		lfsr = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// Bus tasks start and end on a rising edge
	task wr(input [31:0] a, input [31:0] d);
	begin
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
	end
	endtask
	task rd(input [31:0] a, input [31:0] exp);
	begin
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
		#1 chk(rdata, exp);
		chk(rdata_small, (a == `PORT2_MUTE_SELECT_OFFSET) ? 32'h0 : exp);
		@(posedge sys_clk_in);
	end
	endtask
	task final_report;
	begin
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	////////////////////////
	always @(posedge sys_clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			failures = failures + 1;
			final_report;
		end
	end
	initial
	begin
		repeat (20) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		@(posedge sys_clk_in);
		#1 chk({29'h0, mute}, 32'h0);
		@(posedge sys_clk_in);
		for (p = 0; p < 3; p = p + 1)
			rd(offs[p], 32'h0);
		// Every code on every port; the other ports must keep their own source
		for (p = 0; p < 3; p = p + 1)
			for (c = 0; c < 8; c = c + 1)
			begin
				seed = lfsr(seed);
				src <= {seed[6:0], 1'b0};
				repeat (6) @(posedge sys_clk_in);
				wr(offs[p], c);
				sel[p] = c;
				@(posedge sys_clk_in);
				#1 chk({29'h0, mute}, {29'h0, src[sel[2]], src[sel[1]], src[sel[0]]});
				chk({29'h0, mute_small}, {29'h0, 1'b0, src[sel[1]], src[sel[0]]});
				@(posedge sys_clk_in);
				rd(offs[p], c);
			end
		for (c = 0; c < 16; c = c + 1)
		begin
			e = {28'h0, c[3] ^ c[2], c[2], c[1] ^ c[0], c[0]};
			wr(`CLOCK_MODE_OFFSET, c);
			@(posedge sys_clk_in);
			#1 chk({28'h0, rxm, txm}, e);
			@(posedge sys_clk_in);
			rd(`CLOCK_STATUS_OFFSET, e);
		end
		wr(offs[1], 32'h5);
		rd(offs[1], 32'h5);
		rd(32'h4000002c, 32'h0);
		// Reset in mid-run with selectors and clock modes set
		nrst_in <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		@(posedge sys_clk_in);
		#1 chk({29'h0, mute}, 32'h0);
		chk({28'h0, rxm, txm}, 32'h0);
		@(posedge sys_clk_in);
		for (p = 0; p < 3; p = p + 1)
			rd(offs[p], 32'h0);
		final_report;
	end
endmodule
bind audio_port_mute_input_select mute_select_chk chk_i
(
	.sys_clk_in(sys_clk_in),
	.nrst_in(nrst_in),
	.addr_in(addr_in),
	.wdata_in(wdata_in),
	.wr_in(wr_in),
	.rd_in(rd_in),
	.rdata_out(rdata_out),
	.port0_mute_out(port0_mute_out),
	.port1_mute_out(port1_mute_out),
	.port2_mute_out(port2_mute_out),
	.tx_bit_clock_mode_out(tx_bit_clock_mode_out),
	.rx_bit_clock_mode_out(rx_bit_clock_mode_out)
);
`default_nettype wire
